/* File: hw/cdcs_pkg.sv */
/*
  Constants and types of the conversion sequencer.
  Assumes a 32-bit APB register bus and a 200 MHz pclk.
*/
package cdcs_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CYC_OFF = 8'h04;
  localparam logic [7:0] SEQ_OFF = 8'h08;
  localparam logic [7:0] PERIOD_OFF = 8'h0C;
  localparam logic [7:0] CMD_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  localparam logic [7:0] RESULT_OFF = 8'h18;
  ////////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_PRE_BIT = 2;
  localparam int CTRL_FLOAT_BIT = 3;
  localparam int CTRL_ICOMP_BIT = 4;
  localparam int CTRL_ECOMP_BIT = 5;
  localparam int CTRL_PEN_LSB = 6;
  localparam int CTRL_PAIRS_LSB = 11;
  // Cycle, sequence and command field positions
  localparam int CYC_FULL_LSB = 8;
  localparam int CYC_DIS_LSB = 16;
  localparam int SEQ_DUMMY_LSB = 8;
  localparam int SEQ_AVG_LSB = 16;
  localparam int CMD_START_BIT = 0;
  // Status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CAPACT_BIT = 1;
  localparam int ST_COLL_BIT = 5;
  localparam int ST_SHORT_BIT = 6;
  localparam int ST_PERR_LSB = 8;
  localparam int ST_STATE_LSB = 16;
  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0854;
  localparam logic [31:0] CYC_RST = 32'h0100_0810;
  localparam logic [31:0] SEQ_RST = 32'h0001_0110;
  localparam logic [31:0] PERIOD_RST = 32'h0000_0000;
  ////////////////////////////////////////////////////////////////////////////
  // Geometry of a sequence
  localparam int N_PORTS = 6;
  localparam logic [3:0] SLOT_CINT = 4'h9;
  localparam logic [3:0] SLOT_END = 4'hA;
  localparam logic [3:0] SLOT_GND_LAST = 4'h5;
  ////////////////////////////////////////////////////////////////////////////
  // Trigger sources, in selector code order 0..3
  typedef enum logic [1:0] {TRIG_CONT, TRIG_READ, TRIG_TIMER, TRIG_HOST}
    cdcs_trig_t;
endpackage

/* File: hw/cdcs_cyc_if.sv */
/*
  Request and answer between the sequencer and its cycle engine.
  Assumes both ends run on the same pclk.
*/
interface cdcs_cyc_if;
  logic start;
  logic [cdcs_pkg::N_PORTS-1:0] port_mask;
  logic precharge_en;
  logic [7:0] pre_len;
  logic [7:0] full_len;
  logic [15:0] dis_len;
  logic done;
  logic short_err;
  logic [15:0] dis_time;
  // Sequencer side
  modport seq (output start, output port_mask, output precharge_en,
    output pre_len, output full_len, output dis_len,
    input done, input short_err, input dis_time);
  // Engine side
  modport eng (input start, input port_mask, input precharge_en,
    input pre_len, input full_len, input dis_len,
    output done, output short_err, output dis_time);
endinterface

/* File: hw/cdcs_cycle_engine.sv */
/*
  One charge and discharge cycle on a set of ports.
  Assumes cmp_above is synchronous, high above the trigger level,
  and that a start only comes while idle.
*/
module cdcs_cycle_engine (
  input wire logic pclk,
  input wire logic presetn,
  cdcs_cyc_if.eng cyc,
  input wire logic cmp_above,
  output logic [cdcs_pkg::N_PORTS-1:0] precharge_sw,
  output logic [cdcs_pkg::N_PORTS-1:0] fullcharge_sw,
  output logic [cdcs_pkg::N_PORTS-1:0] discharge_sw,
  output logic [cdcs_pkg::N_PORTS-1:0] ground_sw
);
  typedef enum logic [1:0] {E_IDLE, E_PRE, E_FULL, E_DIS} cdcs_eng_t;
  localparam logic [cdcs_pkg::N_PORTS-1:0] ALL_GND = '1;

  cdcs_eng_t state_r;
  logic [15:0] cnt_r;
  logic [15:0] meas_r;
  logic [cdcs_pkg::N_PORTS-1:0] mask_r;
  logic hit_r;
  logic done_r;
  logic short_r;
  logic [15:0] time_r;
  wire cnt_end = (cnt_r <= 16'h0001);
  wire hit_now = hit_r | ~cmp_above;

  ////////////////////////////////////////////////////////////////////////////
  // Precharge, full charge, discharge, ground
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= E_IDLE;
      cnt_r <= 16'h0000;
      meas_r <= 16'h0000;
      mask_r <= '0;
      hit_r <= 1'b0;
      done_r <= 1'b0;
      short_r <= 1'b0;
      time_r <= 16'h0000;
      precharge_sw <= '0;
      fullcharge_sw <= '0;
      discharge_sw <= '0;
      ground_sw <= ALL_GND;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        E_IDLE: begin
          if (cyc.start) begin
            mask_r <= cyc.port_mask;
            ground_sw <= ~cyc.port_mask;
            short_r <= 1'b0;
            if (cyc.precharge_en) begin
              state_r <= E_PRE;
              cnt_r <= {8'h00, cyc.pre_len};
              precharge_sw <= cyc.port_mask;
            end else begin
              state_r <= E_FULL;
              cnt_r <= {8'h00, cyc.full_len};
              fullcharge_sw <= cyc.port_mask;
            end
          end
        end
        E_PRE: begin
          if (!cnt_end) begin
            cnt_r <= cnt_r - 16'h0001;
          end else if (cmp_above) begin
            state_r <= E_FULL;
            cnt_r <= {8'h00, cyc.full_len};
            precharge_sw <= '0;
            fullcharge_sw <= mask_r;
          end else begin
            state_r <= E_IDLE;
            precharge_sw <= '0;
            ground_sw <= ALL_GND;
            done_r <= 1'b1;
            short_r <= 1'b1;
          end
        end
        E_FULL: begin
          if (!cnt_end) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            state_r <= E_DIS;
            cnt_r <= cyc.dis_len;
            fullcharge_sw <= '0;
            discharge_sw <= mask_r;
            meas_r <= 16'h0000;
            hit_r <= 1'b0;
          end
        end
        E_DIS: begin
          // Time of first trigger crossing
          if (!hit_r) begin
            meas_r <= meas_r + 16'h0001;
          end
          if (!hit_r && !cmp_above) begin
            hit_r <= 1'b1;
            time_r <= meas_r;
          end
          if (!cnt_end) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            state_r <= E_IDLE;
            discharge_sw <= '0;
            ground_sw <= ALL_GND;
            done_r <= 1'b1;
            short_r <= ~hit_now;
          end
        end
        default: begin
          state_r <= E_IDLE;
        end
      endcase
    end
  end

  assign cyc.done = done_r;
  assign cyc.short_err = short_r;
  assign cyc.dis_time = time_r;
endmodule

/* File: hw/cdcs_sequencer.sv */
/*
  Conversion sequencer: cycles into sequences and conversions,
  hand-over to resistance unit and DSP, trigger select, APB
  registers.
  Assumes synchronous inputs; resistance_done and dsp_done are
  one-cycle pulses.
*/
module cdcs_sequencer #(
  parameter int PERIOD_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_above,
  input wire logic trigger_pin,
  input wire logic host_read_done,
  input wire logic resistance_done,
  input wire logic dsp_done,
  output logic [cdcs_pkg::N_PORTS-1:0] precharge_sw,
  output logic [cdcs_pkg::N_PORTS-1:0] fullcharge_sw,
  output logic [cdcs_pkg::N_PORTS-1:0] discharge_sw,
  output logic [cdcs_pkg::N_PORTS-1:0] ground_sw,
  output logic eoc_dsp,
  output logic eoc_resistance,
  output logic collision_reset,
  output logic conv_active,
  output logic interrupt_out_n
);
  typedef enum logic [2:0] {
    S_IDLE, S_SLOT, S_CYC, S_GAP, S_EOC, S_RES, S_DSP
  } cdcs_state_t;

  if (PERIOD_W < 1 || PERIOD_W > 32) begin : g_bad_width
    $error("PERIOD_W must lie between 1 and 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot decode: ports measured in a slot
  function automatic logic [cdcs_pkg::N_PORTS:0] slot_decode(
    input logic [3:0] slot,
    input logic floating,
    input logic icomp,
    input logic ecomp,
    input logic [4:0] pen,
    input logic [1:0] pairs
  );
    logic [3:0] pair;
    logic [3:0] part;
    logic [cdcs_pkg::N_PORTS-1:0] pa;
    logic [cdcs_pkg::N_PORTS-1:0] pb;
    pair = slot / 4'h3;
    part = slot - pair * 4'h3;
    pa = '0;
    pb = '0;
    slot_decode = '0;
    if (slot == cdcs_pkg::SLOT_CINT) begin
      slot_decode = {icomp, 6'h00};
    end else if (!floating) begin
      if (slot <= cdcs_pkg::SLOT_GND_LAST) begin
        pa[slot[2:0]] = 1'b1;
        // Reference port always measured first
        slot_decode = {(slot == 4'h0) | pen[slot[2:0] - 3'h1], pa};
      end
    end else if (pair <= {2'b00, pairs}) begin
      pa[{pair[1:0], 1'b0}] = 1'b1;
      pb[{pair[1:0], 1'b1}] = 1'b1;
      case (part)
        4'h0: slot_decode = {ecomp, pa};
        4'h1: slot_decode = {ecomp, pb};
        default: slot_decode = {1'b1, pa | pb};
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [31:0] ctrl_r;
  logic [31:0] cyc_r;
  logic [31:0] seq_r;
  logic [PERIOD_W-1:0] period_r;
  logic [PERIOD_W-1:0] tmr_r;
  logic coll_r;
  logic short_r;
  logic [cdcs_pkg::N_PORTS-1:0] perr_r;
  logic [15:0] result_r;
  cdcs_state_t state_r;
  logic [3:0] slot_r;
  logic [8:0] seq_cnt_r;
  logic [7:0] gap_r;
  logic armed_r;
  logic pin_d_r;
  logic start_r;
  logic [cdcs_pkg::N_PORTS-1:0] mask_r;

  cdcs_cyc_if cyc ();

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields
  wire cdcs_pkg::cdcs_trig_t trig_sel =
    cdcs_pkg::cdcs_trig_t'(ctrl_r[cdcs_pkg::CTRL_TRIG_LSB +: 2]);
  wire pre_en = ctrl_r[cdcs_pkg::CTRL_PRE_BIT];
  wire floating = ctrl_r[cdcs_pkg::CTRL_FLOAT_BIT];
  wire icomp = ctrl_r[cdcs_pkg::CTRL_ICOMP_BIT];
  wire ecomp = ctrl_r[cdcs_pkg::CTRL_ECOMP_BIT];
  wire [4:0] pen = ctrl_r[cdcs_pkg::CTRL_PEN_LSB +: 5];
  wire [1:0] pairs = ctrl_r[cdcs_pkg::CTRL_PAIRS_LSB +: 2];
  wire [7:0] gap_len = seq_r[7:0];
  wire [8:0] seq_total = {1'b0, seq_r[cdcs_pkg::SEQ_DUMMY_LSB +: 8]} +
    {1'b0, seq_r[cdcs_pkg::SEQ_AVG_LSB +: 8]};
  wire [cdcs_pkg::N_PORTS:0] slot_info =
    slot_decode(slot_r, floating, icomp, ecomp, pen, pairs);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  wire apb_wr = apb_done & pwrite;
  wire hit_ctrl = (paddr == cdcs_pkg::CTRL_OFF);
  wire hit_cyc = (paddr == cdcs_pkg::CYC_OFF);
  wire hit_seq = (paddr == cdcs_pkg::SEQ_OFF);
  wire hit_period = (paddr == cdcs_pkg::PERIOD_OFF);
  wire hit_cmd = (paddr == cdcs_pkg::CMD_OFF);
  wire hit_status = (paddr == cdcs_pkg::STATUS_OFF);
  wire hit_result = (paddr == cdcs_pkg::RESULT_OFF);
  wire hit_any = hit_ctrl | hit_cyc | hit_seq | hit_period | hit_cmd |
    hit_status | hit_result;
  wire st_clr = apb_wr & hit_status;

  // Status word as software sees it
  wire [31:0] status_word = (32'h0000_0001 << cdcs_pkg::ST_BUSY_BIT) &
      {32{state_r != S_IDLE}}
    | (32'h0000_0001 << cdcs_pkg::ST_CAPACT_BIT) & {32{conv_active}}
    | (32'h0000_0001 << cdcs_pkg::ST_COLL_BIT) & {32{coll_r}}
    | (32'h0000_0001 << cdcs_pkg::ST_SHORT_BIT) & {32{short_r}}
    | {18'h00000, perr_r, 8'h00}
    | {13'h0000, 3'(state_r), 16'h0000};

  // Read data selection
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r
    : hit_cyc ? cyc_r
    : hit_seq ? seq_r
    : hit_period ? 32'(period_r)
    : hit_status ? status_word
    : hit_result ? {16'h0000, result_r}
    : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger sources
  wire cmd_start = apb_wr & hit_cmd & pwdata[cdcs_pkg::CMD_START_BIT];
  wire pin_rise = trigger_pin & ~pin_d_r;
  wire period_zero = (period_r == '0);
  wire timer_on = (trig_sel == cdcs_pkg::TRIG_TIMER) & ~period_zero;
  wire timer_fire = timer_on & (tmr_r == '0);
  wire read_start = cmd_start | (armed_r & host_read_done);
  wire trig_any = (trig_sel == cdcs_pkg::TRIG_CONT) & (state_r == S_IDLE)
    | (trig_sel == cdcs_pkg::TRIG_READ) & period_zero & read_start
    | timer_fire
    | (trig_sel == cdcs_pkg::TRIG_HOST) & (cmd_start | pin_rise);
  wire go = trig_any & (state_r == S_IDLE);
  wire collide = trig_any & (state_r == S_DSP);
  wire seq_last = (seq_cnt_r + 9'h001 >= seq_total);
  wire gap_end = (gap_r <= 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state, registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~hit_any;
      prdata <= (apb_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= cdcs_pkg::CTRL_RST;
      cyc_r <= cdcs_pkg::CYC_RST;
      seq_r <= cdcs_pkg::SEQ_RST;
      period_r <= PERIOD_W'(cdcs_pkg::PERIOD_RST);
    end else if (apb_wr) begin
      if (hit_ctrl) ctrl_r <= pwdata;
      if (hit_cyc) cyc_r <= pwdata;
      if (hit_seq) seq_r <= pwdata;
      if (hit_period) period_r <= pwdata[PERIOD_W-1:0];
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coll_r <= 1'b0;
      short_r <= 1'b0;
      perr_r <= '0;
    end else begin
      coll_r <= collide | (coll_r & ~(st_clr &
        pwdata[cdcs_pkg::ST_COLL_BIT]));
      short_r <= (cyc.done & cyc.short_err) | (short_r & ~(st_clr &
        pwdata[cdcs_pkg::ST_SHORT_BIT]));
      perr_r <= (mask_r & {cdcs_pkg::N_PORTS{cyc.done & cyc.short_err}})
        | (perr_r & ~({cdcs_pkg::N_PORTS{st_clr}} &
        pwdata[cdcs_pkg::ST_PERR_LSB +: cdcs_pkg::N_PORTS]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timer, reloaded on each expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_r <= '0;
    end else if (!timer_on || timer_fire) begin
      tmr_r <= period_r - PERIOD_W'(1);
    end else begin
      tmr_r <= tmr_r - PERIOD_W'(1);
    end
  end

  // Trigger pin edge and read-mode arming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      pin_d_r <= trigger_pin;
      if (trig_sel != cdcs_pkg::TRIG_READ) begin
        armed_r <= 1'b0;
      end else if (cmd_start) begin
        armed_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      slot_r <= 4'h0;
      seq_cnt_r <= 9'h000;
      gap_r <= 8'h00;
      start_r <= 1'b0;
      mask_r <= '0;
      result_r <= 16'h0000;
      eoc_dsp <= 1'b0;
      eoc_resistance <= 1'b0;
      collision_reset <= 1'b0;
      conv_active <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      start_r <= 1'b0;
      eoc_dsp <= 1'b0;
      eoc_resistance <= 1'b0;
      collision_reset <= collide;
      case (state_r)
        S_IDLE: begin
          if (go) begin
            state_r <= S_SLOT;
            slot_r <= 4'h0;
            seq_cnt_r <= 9'h000;
            conv_active <= 1'b1;
            interrupt_out_n <= 1'b1;
          end
        end
        S_SLOT: begin
          if (slot_r == cdcs_pkg::SLOT_END) begin
            slot_r <= 4'h0;
            seq_cnt_r <= seq_cnt_r + 9'h001;
            if (seq_last) begin
              state_r <= S_EOC;
            end else begin
              state_r <= S_GAP;
              gap_r <= gap_len;
            end
          end else if (slot_info[cdcs_pkg::N_PORTS]) begin
            state_r <= S_CYC;
            start_r <= 1'b1;
            mask_r <= slot_info[cdcs_pkg::N_PORTS-1:0];
          end else begin
            slot_r <= slot_r + 4'h1;
          end
        end
        S_CYC: begin
          if (cyc.done) begin
            state_r <= S_SLOT;
            slot_r <= slot_r + 4'h1;
            result_r <= cyc.dis_time;
          end
        end
        S_GAP: begin
          if (gap_end) begin
            state_r <= S_SLOT;
          end else begin
            gap_r <= gap_r - 8'h01;
          end
        end
        S_EOC: begin
          state_r <= S_RES;
          conv_active <= 1'b0;
          eoc_dsp <= 1'b1;
          eoc_resistance <= 1'b1;
        end
        S_RES: begin
          if (resistance_done) begin
            state_r <= S_DSP;
          end
        end
        S_DSP: begin
          if (collide) begin
            state_r <= S_IDLE;
          end else if (dsp_done) begin
            state_r <= S_IDLE;
            if (trig_sel == cdcs_pkg::TRIG_READ) begin
              interrupt_out_n <= 1'b0;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle engine request
  assign cyc.start = start_r;
  assign cyc.port_mask = mask_r;
  assign cyc.precharge_en = pre_en;
  assign cyc.pre_len = cyc_r[7:0];
  assign cyc.full_len = cyc_r[cdcs_pkg::CYC_FULL_LSB +: 8];
  assign cyc.dis_len = cyc_r[cdcs_pkg::CYC_DIS_LSB +: 16];

  cdcs_cycle_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .cyc(cyc),
    .cmp_above(cmp_above),
    .precharge_sw(precharge_sw),
    .fullcharge_sw(fullcharge_sw),
    .discharge_sw(discharge_sw),
    .ground_sw(ground_sw)
  );
endmodule

/* File: tb/cdcs_sequencer_sva.sv */
/* Port checker of the conversion sequencer.
   Assumes one pclk domain and the async active-low presetn. */
module cdcs_seq_sva #(
  parameter int PERIOD_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic dsp_done,
  input wire logic [5:0] precharge_sw,
  input wire logic [5:0] fullcharge_sw,
  input wire logic [5:0] discharge_sw,
  input wire logic [5:0] ground_sw,
  input wire logic eoc_dsp,
  input wire logic eoc_resistance,
  input wire logic collision_reset,
  input wire logic conv_active,
  input wire logic interrupt_out_n
);
  logic chain_r;
  logic chain_nxt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Busy from eoc until DSP done or collision reset
  assign chain_nxt = eoc_dsp | (chain_r & ~dsp_done & ~collision_reset);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_r <= 1'b0;
    end else begin
      chain_r <= chain_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Conversion end and hand-over order
  eoc_pair_a: assert property (eoc_dsp == eoc_resistance)
    else $error("eoc pulses differ");
  eoc_pulse_a: assert property (eoc_dsp |=> !eoc_dsp)
    else $error("eoc longer than one cycle");
  eoc_stop_a: assert property (eoc_dsp |-> ##[0:1] !conv_active)
    else $error("conversion runs past eoc");
  chain_order_a: assert property ($rose(conv_active) |-> !chain_r)
    else $error("conversion before DSP done");
  int_fall_a: assert property ($fell(interrupt_out_n) |->
    $past(dsp_done) || $past(dsp_done, 2) || $past(dsp_done, 3))
    else $error("interrupt without DSP done");
  coll_idle_a: assert property (collision_reset |-> !conv_active)
    else $error("collision while converting");
  // Switch integrity
  dis_ground_a: assert property ((discharge_sw & ground_sw) == 6'h00)
    else $error("discharge and ground together");
  chg_dis_a: assert property (
    (discharge_sw & (precharge_sw | fullcharge_sw)) == 6'h00)
    else $error("charge and discharge together");
  idle_ground_a: assert property (
    !conv_active && !$past(conv_active) |-> ground_sw == 6'h3F)
    else $error("idle port not grounded");
  // Register bus timing
  acc_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  eoc_c: cover property (eoc_dsp);
  coll_c: cover property (collision_reset);
  int_c: cover property ($fell(interrupt_out_n));
endmodule
bind cdcs_sequencer cdcs_seq_sva #(.PERIOD_W(PERIOD_W)) sva (.pclk,
  .presetn, .psel, .penable, .pready, .dsp_done, .precharge_sw,
  .fullcharge_sw, .discharge_sw, .ground_sw, .eoc_dsp, .eoc_resistance,
  .collision_reset, .conv_active, .interrupt_out_n);

/* File: tb/cdcs_far_model.sv */
/* Far side: resistance unit, DSP and host controller.
   Assumes lat of at least 1, steady in a chain. */
module cdcs_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic eoc_resistance,
  input wire logic interrupt_out_n,
  input wire logic [7:0] lat,
  input wire logic read_en,
  output logic resistance_done,
  output logic dsp_done,
  output logic host_read_done
);
  int rc = 0, hc = 0;
  logic int_d = 1'b1;
  initial {resistance_done, dsp_done, host_read_done} = 3'b000;
  // Resistance then DSP, lat cycles each; host read after interrupt
  always @(posedge pclk) begin
    if (!presetn) begin
      rc <= 0;
      hc <= 0;
    end else begin
      rc <= eoc_resistance ? 1 : (rc > 0 && rc < 2 * lat) ? rc + 1 : 0;
      resistance_done <= (rc == lat);
      dsp_done <= (rc == 2 * lat);
      int_d <= interrupt_out_n;
      hc <= (read_en && int_d && !interrupt_out_n) ? 1 :
        (hc > 0 && hc < lat) ? hc + 1 : 0;
      host_read_done <= (hc == lat);
    end
  end
endmodule

/* File: tb/cdcs_sequencer_bench.sv */
/* Self-checking bench of the sequencer.
   Assumes the far model answers the design's pulses. */
module cdcs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CMD = cdcs_pkg::CMD_OFF;
  localparam logic [7:0] STAT = cdcs_pkg::STATUS_OFF;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cmp_above = 1'b0, trigger_pin = 1'b0;
  logic shorted = 1'b0, read_en = 1'b0;
  logic [7:0] lat = 8'h04;
  logic [31:0] prdata, q;
  logic [5:0] precharge_sw, fullcharge_sw, discharge_sw, ground_sw;
  logic [5:0] dis_d = 6'h00;
  logic [5:0] masks[$];
  logic pready, pslverr, slv_err, resistance_done, dsp_done;
  logic host_read_done, eoc_dsp, eoc_resistance, collision_reset;
  logic conv_active, interrupt_out_n;
  logic full_seen = 1'b0, pre_seen = 1'b0;
  int bad_count = 0, num_checks = 0, n_eoc = 0, n_coll = 0, n0;
  // Clock, design and far side
  always #2.5 pclk = ~pclk;
  cdcs_sequencer #(.PERIOD_W(24)) uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_above,
    .trigger_pin, .host_read_done, .resistance_done, .dsp_done,
    .precharge_sw, .fullcharge_sw, .discharge_sw, .ground_sw, .eoc_dsp,
    .eoc_resistance, .collision_reset, .conv_active, .interrupt_out_n);
  cdcs_far_model far (.pclk, .presetn, .eoc_resistance, .interrupt_out_n,
    .lat, .read_en, .resistance_done, .dsp_done, .host_read_done);
  // Node above trigger unless discharging or shorted
  always @(posedge pclk) cmp_above <= !shorted && ~|discharge_sw;
  // Logs masks, charge phases, pulses
  always @(negedge pclk) begin
    if (discharge_sw != dis_d && |discharge_sw)
      masks.push_back(discharge_sw);
    dis_d = discharge_sw;
    full_seen |= |fullcharge_sw;
    pre_seen |= |precharge_sw;
    n_eoc += eoc_dsp;
    n_coll += collision_reset;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_sig(ref logic s, input logic v);
    for (int n = 0; n < 3000 && s !== v; n++) @(negedge pclk);
    check("wait", s, v);
    @(posedge pclk);
  endtask
  // New mode, wait for idle, clear logs
  task automatic mode(input logic [31:0] ctrl);
    apb(1'b1, cdcs_pkg::CTRL_OFF, ctrl);
    do apb(1'b0, STAT, 32'h0); while (q[0] !== 1'b0);
    masks.delete();
    full_seen = 1'b0;
    pre_seen = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge pclk);
    check("auto start", conv_active, 1'b1);
    apb(1'b0, cdcs_pkg::CTRL_OFF, 32'h0);
    check("ctrl", q, cdcs_pkg::CTRL_RST);
    apb(1'b0, cdcs_pkg::CYC_OFF, 32'h0);
    check("cyc", q, cdcs_pkg::CYC_RST);
    apb(1'b0, cdcs_pkg::SEQ_OFF, 32'h0);
    check("seq", q, cdcs_pkg::SEQ_RST);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {q[30:0], slv_err}, 32'h1);
    wait_sig(eoc_dsp, 1'b1);
    wait_sig(dsp_done, 1'b1);
    wait_sig(conv_active, 1'b1);
    apb(1'b1, cdcs_pkg::CYC_OFF, 32'h0004_0202);
    apb(1'b1, cdcs_pkg::SEQ_OFF, 32'h0002_0002);
    $display("reset test done");
  endtask
  task automatic t_ground();
    mode(32'h0000_00D7);
    apb(1'b1, CMD, 32'h1);
    wait_sig(eoc_dsp, 1'b1);
    check("port a", masks[0], 6'h01);
    check("port b", masks[1], 6'h02);
    check("port c", masks[2], 6'h04);
    check("next seq", masks[3], 6'h01);
    mode(32'h0000_00D3);
    trigger_pin <= 1'b1;
    @(posedge pclk);
    trigger_pin <= 1'b0;
    wait_sig(eoc_dsp, 1'b1);
    check("no precharge", {pre_seen, full_seen}, 32'h1);
    $display("grounded test done");
  endtask
  task automatic t_float();
    logic [35:0] e = {6'h0C, 6'h08, 6'h04, 6'h03, 6'h02, 6'h01};
    mode(32'h0000_09EF);
    apb(1'b1, CMD, 32'h1);
    wait_sig(eoc_dsp, 1'b1);
    for (int i = 0; i < 6; i++) begin
      check("float", masks[i], e[6*i +: 6]);
    end
    $display("floating test done");
  endtask
  task automatic t_short();
    mode(32'h0000_00C7);
    shorted <= 1'b1;
    apb(1'b1, CMD, 32'h1);
    wait_sig(eoc_dsp, 1'b1);
    check("full after short", full_seen, 1'b0);
    apb(1'b0, STAT, 32'h0);
    check("port error", q[8], 1'b1);
    shorted <= 1'b0;
    $display("short test done");
  endtask
  task automatic t_read();
    lat <= 8'h1E;
    read_en <= 1'b1;
    mode(32'h0000_00D5);
    apb(1'b1, CMD, 32'h1);
    wait_sig(interrupt_out_n, 1'b0);
    n0 = n_eoc;
    wait_sig(conv_active, 1'b1);
    wait_sig(eoc_dsp, 1'b1);
    check("read restart", n_eoc - n0, 32'h1);
    read_en <= 1'b0;
    lat <= 8'h04;
    $display("read test done");
  endtask
  task automatic t_timer();
    apb(1'b1, cdcs_pkg::PERIOD_OFF, 32'd300);
    mode(32'h0000_00D6);
    wait_sig(eoc_dsp, 1'b1);
    n0 = n_eoc;
    // 3.5 periods
    repeat (1050) @(posedge pclk);
    check("timer count", n_eoc - n0, 32'h3);
    apb(1'b1, cdcs_pkg::PERIOD_OFF, 32'h0);
    $display("timer test done");
  endtask
  task automatic t_coll();
    lat <= 8'h28;
    mode(32'h0000_00D7);
    n0 = n_eoc;
    apb(1'b1, CMD, 32'h1);
    apb(1'b1, CMD, 32'h1);
    wait_sig(eoc_dsp, 1'b1);
    wait_sig(resistance_done, 1'b1);
    apb(1'b1, CMD, 32'h1);
    check("collision pulse", n_coll, 32'h1);
    check("one conversion", n_eoc - n0, 32'h1);
    apb(1'b0, STAT, 32'h0);
    check("collision flag", q[5], 1'b1);
    $display("collision test done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset, then every scenario in turn
  initial begin
    repeat (3) @(posedge pclk);
    check("reset ground", ground_sw, 6'h3F);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_ground();
    t_float();
    t_short();
    t_read();
    t_timer();
    t_coll();
    stop_test();
  end
  // Watchdog against hangs
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    stop_test();
  end
endmodule
